/* File: drive_operation_mode_selector.sv */
`timescale 1ns/10ps
`default_nettype none
`include "opmode_params.svh"
module drive_operation_mode_selector
  import opmode_pkg::*;
(
  input  wire logic                 clk_sys_in,          // control clock
  input  wire logic                 rstn_in,             // async reset, low
  input  wire logic [3:0]           mode_select_param_in,// operation mode selection
  input  wire logic [7:0]           startup_mode_param_in,// start-up mode
  input  wire logic [1:0]           stop_logic_param_in, // output-stop logic
  input  wire logic [`N_IN_TERM-1:0][7:0] input_function_param_in, // per terminal
  input  wire logic [`N_IN_TERM-1:0] terminal_in,        // input terminal levels
  input  wire logic                 output_stop_in,      // output-stop input
  input  wire logic [`N_OUT_TERM-1:0][7:0] output_function_param_in, // per output
  input  wire logic                 motor_running_in,    // motor not stopped
  input  wire logic                 mode_toggle_key_in,  // toggle key pulse
  input  wire logic                 panel_select_in,     // select panel mode pulse
  input  wire logic                 external_key_in,     // external-mode key pulse
  input  wire logic                 net_cmd_net_in,      // network: go network pulse
  input  wire logic                 net_cmd_ext_in,      // network: go external pulse
  input  wire logic                 panel_new_cmd_in,    // panel issued new command
  input  wire logic                 net_new_cmd_in,      // network issued new command
  input  wire logic                 forward_start_in,    // forward start terminal
  input  wire logic                 reverse_start_in,    // reverse start terminal
  input  wire logic                 panel_fwd_in,        // panel forward run
  input  wire logic                 panel_rev_in,        // panel reverse run
  input  wire logic                 net_fwd_in,          // network forward run
  input  wire logic                 net_rev_in,          // network reverse run
  input  wire logic                 jog_in,              // jog terminal
  input  wire logic                 multi_sel_in,        // multi-speed selected
  input  wire logic                 current_input_enable,// current input enable
  input  wire logic [`FREQ_W-1:0]   jog_freq_in,         // jog frequency
  input  wire logic [`FREQ_W-1:0]   multi_freq_in,       // multi-speed frequency
  input  wire logic [`FREQ_W-1:0]   volt_freq_in,        // voltage analog input
  input  wire logic [`FREQ_W-1:0]   cur_freq_in,         // current analog input
  input  wire logic [`FREQ_W-1:0]   panel_freq_in,       // panel set frequency
  input  wire logic [`FREQ_W-1:0]   net_freq_in,         // network set frequency
  input  wire logic                 param_write_req_in,  // write request pulse
  input  wire logic [9:0]           param_num_in,        // parameter number
  input  wire logic                 param_ext_ok_in,     // writable in external mode
  input  wire logic                 param_cond_ok_in,    // write selection allows
  output mode_t                     op_mode_out,         // current mode
  output logic                      run_fwd_out,         // forward run command
  output logic                      run_rev_out,         // reverse run command
  output logic [`FREQ_W-1:0]        freq_cmd_out,        // set frequency
  output logic                      output_stop_out,     // inverter output stop
  output logic                      interlock_on_out,    // interlock level seen
  output logic [`N_OUT_TERM-1:0]    output_terminal_out, // output terminals
  output logic                      param_write_ack_out, // write accepted
  output logic                      param_write_nak_out  // write refused
);

  // ----------------------------------------------------------------
  // terminal decode
  // ----------------------------------------------------------------
  logic ilock_asg;
  logic ilock_raw;
  logic sw16_asg;
  logic sw16_lvl;
  logic sw65_asg;
  logic sw65_lvl;
  logic sw66_asg;
  logic sw66_lvl;
  logic ilock_on;

  // a function assigned to several terminals reads as their OR
  always_comb
  begin
    ilock_asg = 1'b0;
    ilock_raw = 1'b0;
    sw16_asg  = 1'b0;
    sw16_lvl  = 1'b0;
    sw65_asg  = 1'b0;
    sw65_lvl  = 1'b0;
    sw66_asg  = 1'b0;
    sw66_lvl  = 1'b0;
    for (int i = 0; i < `N_IN_TERM; i++)
    begin
      if (input_function_param_in[i] == `IN_CODE_ILOCK)
      begin
        ilock_asg = 1'b1;
        ilock_raw = ilock_raw | terminal_in[i];
      end
      if (input_function_param_in[i] == `IN_CODE_MODE_TOGGLE_KEY)
      begin
        sw16_asg = 1'b1;
        sw16_lvl = sw16_lvl | terminal_in[i];
      end
      if (input_function_param_in[i] == `IN_CODE_PU_NET)
      begin
        sw65_asg = 1'b1;
        sw65_lvl = sw65_lvl | terminal_in[i];
      end
      if (input_function_param_in[i] == `IN_CODE_EXT_NET)
      begin
        sw66_asg = 1'b1;
        sw66_lvl = sw66_lvl | terminal_in[i];
      end
    end
  end

  // output-stop input stands in when no terminal carries the interlock
  logic ilock_src;
  assign ilock_src = ilock_asg ? ilock_raw : output_stop_in;
  assign ilock_on  = (stop_logic_param_in == `STOP_LOGIC_INV) ?
                     ~ilock_src : ilock_src;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mode_t               mode_ff;
  mode_t               nxt_mode;
  logic                init_done_ff;
  logic                sw16_ff;
  logic                sw65_ff;
  logic                sw66_ff;
  logic                held_ff;
  logic                held_fwd_ff;
  logic                held_rev_ff;
  logic [`FREQ_W-1:0]  held_freq_ff;
  logic                run_fwd_ff;
  logic                run_rev_ff;
  logic [`FREQ_W-1:0]  freq_ff;

  // ----------------------------------------------------------------
  // switching permissions
  // ----------------------------------------------------------------
  logic [3:0] msel;
  logic       stopped;
  logic       can_sw;
  logic       net_ok;
  logic       e16;
  logic       e65;
  logic       e66;

  assign msel    = mode_select_param_in;
  assign stopped = ~motor_running_in;
  // switch-over mode changes mode while running
  assign can_sw  = ((msel == `MSEL_EXT_TOGGLE) & stopped) |
                   (msel == `MSEL_SWITCH) |
                   ((msel == `MSEL_ILOCK) & ilock_on & stopped);
  // fixed external still moves to and from network
  assign net_ok  = can_sw | ((msel == `MSEL_EXT_FIXED) & stopped);
  // switch terminals act on a change of level, so a held level is no lock
  assign e16 = sw16_asg & (sw16_lvl ^ sw16_ff);
  assign e65 = sw65_asg & (sw65_lvl ^ sw65_ff);
  assign e66 = sw66_asg & (sw66_lvl ^ sw66_ff);

  // ----------------------------------------------------------------
  // next mode, in priority order
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_mode = mode_ff;
    if (!init_done_ff)
    begin
      // power-on mode; start-up parameter ranks last
      unique case (msel)
        `MSEL_PU_FIXED: nxt_mode = MODE_PU;
        `MSEL_COMB1:    nxt_mode = MODE_COMB1;
        `MSEL_COMB2:    nxt_mode = MODE_COMB2;
        `MSEL_EXT_TOGGLE, `MSEL_EXT_FIXED, `MSEL_SWITCH:
          if ((startup_mode_param_in == `STARTUP_NET_A) ||
              (startup_mode_param_in == `STARTUP_NET_B))
            nxt_mode = MODE_NET;
          else
            nxt_mode = MODE_EXT;
        default:        nxt_mode = MODE_EXT;
      endcase
    end
    else if (msel == `MSEL_PU_FIXED)
      nxt_mode = MODE_PU;
    else if (msel == `MSEL_COMB1)
      nxt_mode = MODE_COMB1;
    else if (msel == `MSEL_COMB2)
      nxt_mode = MODE_COMB2;
    else if ((msel == `MSEL_ILOCK) && !ilock_on)
      nxt_mode = MODE_EXT;
    else if ((mode_ff == MODE_COMB1) || (mode_ff == MODE_COMB2))
      nxt_mode = MODE_EXT;
    else if ((msel == `MSEL_EXT_FIXED) && (mode_ff == MODE_PU))
      nxt_mode = MODE_EXT;
    else if (e66 && net_ok)
      nxt_mode = sw66_lvl ? MODE_NET : MODE_EXT;
    else if (e65 && can_sw)
      nxt_mode = sw65_lvl ? MODE_NET : MODE_PU;
    else if (e16 && can_sw)
      nxt_mode = sw16_lvl ? MODE_EXT : MODE_PU;
    else if (net_cmd_net_in && net_ok && (mode_ff != MODE_NET))
      nxt_mode = MODE_NET;
    else if (net_cmd_ext_in && net_ok && (mode_ff == MODE_NET))
      nxt_mode = MODE_EXT;
    else if (mode_toggle_key_in && can_sw && (mode_ff != MODE_NET))
      nxt_mode = (mode_ff == MODE_EXT) ? MODE_PU : MODE_EXT;
    else if (panel_select_in && can_sw)
      nxt_mode = MODE_PU;
    else if (external_key_in && can_sw && (mode_ff == MODE_PU))
      nxt_mode = MODE_EXT;
  end

  // mode register; reset parks in external until the first edge decides
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      mode_ff      <= MODE_EXT;
      init_done_ff <= 1'b0;
    end
    else
    begin
      mode_ff      <= nxt_mode;
      init_done_ff <= 1'b1;
    end
  end

  // previous switch levels; first sample loads without counting as change
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sw16_ff <= 1'b0;
      sw65_ff <= 1'b0;
      sw66_ff <= 1'b0;
    end
    else
    begin
      sw16_ff <= sw16_lvl;
      sw65_ff <= sw65_lvl;
      sw66_ff <= sw66_lvl;
    end
  end

  // ----------------------------------------------------------------
  // carried-over direction and frequency
  // ----------------------------------------------------------------
  logic carry;
  logic drop;

  // only switch-over mode carries the running command across
  assign carry = (msel == `MSEL_SWITCH) && (nxt_mode != mode_ff) &&
                 ((nxt_mode == MODE_PU) || (nxt_mode == MODE_NET));
  // a new command from the owning source retires the carried one
  assign drop  = (nxt_mode == MODE_EXT) ||
                 ((mode_ff == MODE_PU) && panel_new_cmd_in) ||
                 ((mode_ff == MODE_NET) && net_new_cmd_in);

  // capture beats retire; only reset loses it otherwise
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      held_ff      <= 1'b0;
      held_fwd_ff  <= 1'b0;
      held_rev_ff  <= 1'b0;
      held_freq_ff <= '0;
    end
    else if (carry)
    begin
      held_ff      <= 1'b1;
      held_fwd_ff  <= run_fwd_ff;
      held_rev_ff  <= run_rev_ff;
      held_freq_ff <= freq_ff;
    end
    else if (drop)
      held_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // command sources
  // ----------------------------------------------------------------
  run_cmd_if cmd ();

  always_comb
  begin
    unique case (mode_ff)
      MODE_EXT:
      begin
        cmd.run_src  = RUN_EXT;
        cmd.freq_src = FREQ_EXT;
      end
      MODE_PU:
      begin
        cmd.run_src  = held_ff ? RUN_HELD : RUN_PANEL;
        cmd.freq_src = held_ff ? FREQ_HELD : FREQ_PANEL;
      end
      MODE_NET:
      begin
        cmd.run_src  = held_ff ? RUN_HELD : RUN_NET;
        cmd.freq_src = held_ff ? FREQ_HELD : FREQ_NET;
      end
      MODE_COMB1:
      begin
        cmd.run_src  = RUN_EXT;
        cmd.freq_src = FREQ_COMB1;
      end
      MODE_COMB2:
      begin
        cmd.run_src  = RUN_PANEL;
        cmd.freq_src = FREQ_EXT;
      end
      default:
      begin
        cmd.run_src  = RUN_EXT;
        cmd.freq_src = FREQ_EXT;
      end
    endcase
  end

  assign cmd.held_fwd  = held_fwd_ff;
  assign cmd.held_rev  = held_rev_ff;
  assign cmd.held_freq = held_freq_ff;

  run_cmd_mux u_mux (
    .sel           (cmd.mux),
    .ext_fwd_in    (forward_start_in),
    .ext_rev_in    (reverse_start_in),
    .panel_fwd_in  (panel_fwd_in),
    .panel_rev_in  (panel_rev_in),
    .net_fwd_in    (net_fwd_in),
    .net_rev_in    (net_rev_in),
    .jog_in        (jog_in),
    .multi_sel_in  (multi_sel_in),
    .cur_en_in     (current_input_enable),
    .jog_freq_in   (jog_freq_in),
    .multi_freq_in (multi_freq_in),
    .volt_freq_in  (volt_freq_in),
    .cur_freq_in   (cur_freq_in),
    .panel_freq_in (panel_freq_in),
    .net_freq_in   (net_freq_in)
  );

  // registered run command; also the value carried at a switch-over
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      run_fwd_ff <= 1'b0;
      run_rev_ff <= 1'b0;
      freq_ff    <= '0;
    end
    else
    begin
      run_fwd_ff <= cmd.cmd_fwd;
      run_rev_ff <= cmd.cmd_rev;
      freq_ff    <= cmd.cmd_freq;
    end
  end

  // ----------------------------------------------------------------
  // output stop and indications
  // ----------------------------------------------------------------
  logic                   stop_ff;
  logic                   ilock_ff;
  logic [`N_OUT_TERM-1:0] out_term_ff;
  logic [`N_OUT_TERM-1:0] nxt_out_term;

  // outputs with other codes belong to other functions and idle low
  always_comb
  begin
    for (int j = 0; j < `N_OUT_TERM; j++)
    begin
      if (output_function_param_in[j] == `OUT_CODE_PU_POS)
        nxt_out_term[j] = (nxt_mode == MODE_PU);
      else if (output_function_param_in[j] == `OUT_CODE_PU_NEG)
        nxt_out_term[j] = (nxt_mode != MODE_PU);
      else
        nxt_out_term[j] = 1'b0;
    end
  end

  // under mode 7 the output-stop input may be the interlock, not a stop
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      stop_ff     <= 1'b0;
      ilock_ff    <= 1'b0;
      out_term_ff <= '0;
    end
    else
    begin
      if (msel == `MSEL_ILOCK)
        stop_ff <= ilock_on && (nxt_mode == MODE_EXT);
      else
        stop_ff <= output_stop_in;
      ilock_ff    <= ilock_on;
      out_term_ff <= nxt_out_term;
    end
  end

  // ----------------------------------------------------------------
  // parameter write gate
  // ----------------------------------------------------------------
  logic ack_ff;
  logic nak_ff;
  logic wr_ok;

  always_comb
  begin
    if ((msel == `MSEL_ILOCK) && !ilock_on)
      wr_ok = (param_num_in == `MODE_SELECT_NUM);
    else if (mode_ff == MODE_EXT)
      wr_ok = param_ext_ok_in && param_cond_ok_in;
    else
      wr_ok = param_cond_ok_in;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ack_ff <= 1'b0;
      nak_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= param_write_req_in && wr_ok;
      nak_ff <= param_write_req_in && !wr_ok;
    end
  end

  assign op_mode_out         = mode_ff;
  assign run_fwd_out         = run_fwd_ff;
  assign run_rev_out         = run_rev_ff;
  assign freq_cmd_out        = freq_ff;
  assign output_stop_out     = stop_ff;
  assign interlock_on_out    = ilock_ff;
  assign output_terminal_out = out_term_ff;
  assign param_write_ack_out = ack_ff;
  assign param_write_nak_out = nak_ff;

endmodule
`default_nettype wire

/* File: drive_operation_mode_selector_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
`include "opmode_params.svh"
module drive_operation_mode_selector_asserts
  import opmode_pkg::*;
(
  input wire logic                        clk_sys_in,               // clock
  input wire logic                        rstn_in,                  // reset
  input wire logic [3:0]                  mode_select_param_in,     // mode select
  input wire logic [`N_OUT_TERM-1:0][7:0] output_function_param_in, // output codes
  input wire logic                        motor_running_in,         // running
  input wire logic                        mode_toggle_key_in,       // toggle key
  input wire logic                        param_write_req_in,       // write req
  input wire logic [9:0]                  param_num_in,             // param number
  input wire mode_t                       op_mode_out,              // mode
  input wire logic                        interlock_on_out,         // interlock
  input wire logic [`N_OUT_TERM-1:0]      output_terminal_out,      // outputs
  input wire logic                        param_write_ack_out,      // ack
  input wire logic                        param_write_nak_out       // nak
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // power-on mode settles on the first edge, so key checks wait for the third
  logic [1:0] up_ff;
  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in) up_ff <= 2'h0;
    else if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
  wire logic key = up_ff == 2'h3 && !motor_running_in && mode_toggle_key_in;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_tog_pu; key && mode_select_param_in == 4'h0 && op_mode_out == MODE_EXT
    |=> op_mode_out == MODE_PU; endproperty
  a_tog_pu: assert property (p_tog_pu) else $error("toggle to panel missed");
  property p_tog_ext; key && mode_select_param_in == 4'h0 && op_mode_out == MODE_PU
    |=> op_mode_out == MODE_EXT; endproperty
  a_tog_ext: assert property (p_tog_ext) else $error("toggle back missed");
  property p_ext_fix; key && mode_select_param_in == 4'h2 |=> $stable(op_mode_out); endproperty
  a_ext_fix: assert property (p_ext_fix) else $error("mode 2 moved");
  property p_pu_fix; up_ff == 2'h3 && mode_select_param_in == 4'h1 |-> op_mode_out == MODE_PU;
  endproperty
  a_pu_fix: assert property (p_pu_fix) else $error("mode 1 left panel");
  property p_comb_fix; key && mode_select_param_in inside {4'h3, 4'h4} |=> $stable(op_mode_out);
  endproperty
  a_comb_fix: assert property (p_comb_fix) else $error("combined moved");
  property p_lock; mode_select_param_in == 4'h7 && !interlock_on_out
    |=> op_mode_out == MODE_EXT; endproperty
  a_lock: assert property (p_lock) else $error("interlock off not external");
  property p_wr_one; param_write_req_in |=> param_write_ack_out != param_write_nak_out;
  endproperty
  a_wr_one: assert property (p_wr_one) else $error("write answer wrong");
  property p_wr_lock; mode_select_param_in == 4'h7 && !interlock_on_out && param_write_req_in
    && param_num_in != 10'h04F |=> param_write_nak_out; endproperty
  a_wr_lock: assert property (p_wr_lock) else $error("locked write taken");
  property p_ind; up_ff != 2'h0 && output_function_param_in[0] == 8'h0A
    && output_function_param_in[1] == 8'h6E
    |-> output_terminal_out[1:0] == ({2{op_mode_out == MODE_PU}} ^ 2'h2); endproperty
  a_ind: assert property (p_ind) else $error("panel indication wrong");
  c_pu: cover property (op_mode_out == MODE_PU);
  c_net: cover property (op_mode_out == MODE_NET);
  c_nak: cover property (param_write_nak_out);
endmodule
`default_nettype wire

/* File: drive_operation_mode_selector_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "opmode_params.svh"
module drive_operation_mode_selector_tb_top;
  import opmode_pkg::*;
  logic clk_sys_in = 0, rstn_in = 0, motor_running_in = 0, mode_toggle_key_in = 0;
  logic panel_select_in = 0, external_key_in = 0, net_cmd_net_in, net_cmd_ext_in;
  logic panel_new_cmd_in = 0, net_new_cmd_in = 0, forward_start_in = 0, reverse_start_in = 0;
  logic panel_fwd_in = 0, panel_rev_in = 0, net_fwd_in = 0, net_rev_in = 0, jog_in = 0;
  logic multi_sel_in = 0, current_input_enable = 0, output_stop_in = 0, param_write_req_in = 0;
  logic param_ext_ok_in = 0, param_cond_ok_in = 1, run_fwd_out, run_rev_out, output_stop_out;
  logic interlock_on_out, param_write_ack_out, param_write_nak_out;
  logic [3:0] mode_select_param_in = 0;
  logic [7:0] startup_mode_param_in = 0;
  logic [1:0] stop_logic_param_in = 0;
  logic [9:0] param_num_in = 0;
  logic [`N_IN_TERM-1:0][7:0] input_function_param_in = '0;
  logic [`N_IN_TERM-1:0] terminal_in = '0;
  logic [`N_OUT_TERM-1:0][7:0] output_function_param_in = {8'h00, 8'h6E, 8'h0A};
  logic [`N_OUT_TERM-1:0] output_terminal_out;
  logic [15:0] jog_freq_in = 0, multi_freq_in = 0, volt_freq_in = 0, cur_freq_in = 0;
  logic [15:0] panel_freq_in = 16'h0777, net_freq_in = 0, freq_cmd_out;
  mode_t op_mode_out;
  int miscompares = 0, n_checks = 0;
  logic [3:0] sel [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
  mode_t boot [6] = '{MODE_EXT, MODE_PU, MODE_EXT, MODE_COMB1, MODE_COMB2, MODE_EXT};
  mode_t tog [6] = '{MODE_PU, MODE_PU, MODE_EXT, MODE_COMB1, MODE_COMB2, MODE_EXT};
  drive_operation_mode_selector u_dut (.*);
  opmode_net_master u_net (.clk_in(clk_sys_in), .go_net_out(net_cmd_net_in),
                           .go_ext_out(net_cmd_ext_in));
  always #5 clk_sys_in = ~clk_sys_in;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // reset is held six cycles with the chosen mode select
  task automatic rst(input logic [3:0] m);
    rstn_in <= 0;
    mode_select_param_in <= m;
    repeat (6) @(posedge clk_sys_in);
    rstn_in <= 1;
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic pulse(input logic tog);
    @(posedge clk_sys_in);
    mode_toggle_key_in <= tog;
    panel_select_in <= !tog;
    @(posedge clk_sys_in);
    {mode_toggle_key_in, panel_select_in} <= 2'h0;
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wr(input logic [9:0] n, input logic ok, input logic [1:0] exp);
    @(posedge clk_sys_in);
    param_write_req_in <= 1;
    param_num_in <= n;
    param_ext_ok_in <= ok;
    @(posedge clk_sys_in) param_write_req_in <= 0;
    #1 chk({param_write_ack_out, param_write_nak_out}, exp);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    foreach (sel[i])
    begin
      rst(sel[i]);
      chk(op_mode_out, boot[i]);
      pulse(1);
      chk(op_mode_out, tog[i]);
    end
    wr(10'h04F, 0, 2'b10);
    wr(10'h005, 1, 2'b01);
    stop_logic_param_in <= 2'h2;
    pulse(1);
    pulse(1);
    chk({output_stop_out, op_mode_out}, 4'h8);
    rst(4'h0);
    wr(10'h005, 0, 2'b01);
    wr(10'h005, 1, 2'b10);
    $display("boot, toggle and write tests done");
    rst(4'h6);
    forward_start_in <= 1;
    volt_freq_in <= 16'h1234;
    motor_running_in <= 1;
    repeat (3) @(posedge clk_sys_in);
    #1 chk({run_rev_out, run_fwd_out, freq_cmd_out}, 17'h11234);
    pulse(0);
    @(posedge clk_sys_in) volt_freq_in <= 16'h0055;
    repeat (3) @(posedge clk_sys_in);
    #1 chk({op_mode_out, freq_cmd_out}, 19'h11234);
    u_net.send(1);
    #1 chk({op_mode_out, freq_cmd_out}, 19'h21234);
    u_net.send(0);
    #1 chk({op_mode_out, freq_cmd_out}, 19'h00055);
    $display("switch-over test done");
    conclude();
  end
  initial
  begin
    #100000;
    miscompares++;
    conclude();
  end
endmodule
bind drive_operation_mode_selector drive_operation_mode_selector_asserts u_chk (.*);
`default_nettype wire

/* File: opmode_net_master.sv */
`timescale 1ns/10ps
`default_nettype none
// network master: sends mode-change commands as one-cycle pulses
module opmode_net_master (
  input  wire logic        clk_in,     // control clock
  output logic             go_net_out = 1'b0, // go network command
  output logic             go_ext_out = 1'b0  // go external command
);
  task automatic send(input logic to_net);
    @(posedge clk_in);
    go_net_out <= to_net;
    go_ext_out <= !to_net;
    @(posedge clk_in);
    go_net_out <= 1'b0;
    go_ext_out <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

/* File: opmode_params.svh */
`ifndef OPMODE_PARAMS_SVH
`define OPMODE_PARAMS_SVH
// mode-select parameter values
`define MSEL_EXT_TOGGLE 4'h0
`define MSEL_PU_FIXED   4'h1
`define MSEL_EXT_FIXED  4'h2
`define MSEL_COMB1      4'h3
`define MSEL_COMB2      4'h4
`define MSEL_SWITCH     4'h6
`define MSEL_ILOCK      4'h7
// input terminal function codes
`define IN_CODE_ILOCK   8'h0C
`define IN_CODE_MODE_TOGGLE_KEY  8'h10
`define IN_CODE_PU_NET  8'h41
`define IN_CODE_EXT_NET 8'h42
// output terminal function codes for the panel-mode indication
`define OUT_CODE_PU_POS 8'h0A
`define OUT_CODE_PU_NEG 8'h6E
// stop logic value that inverts the interlock sense
`define STOP_LOGIC_INV  2'h2
// start-up mode values that power up in network mode
`define STARTUP_NET_A   8'h01
`define STARTUP_NET_B   8'h0A
// parameter number of the mode-select parameter
`define MODE_SELECT_NUM 10'h04F
// terminal counts and frequency width
`define N_IN_TERM       7
`define N_OUT_TERM      3
`define FREQ_W          16
`endif

/* File: opmode_pkg.sv */
package opmode_pkg;
  typedef enum logic [2:0] {MODE_EXT, MODE_PU, MODE_NET, MODE_COMB1, MODE_COMB2} mode_t;
  typedef enum logic [1:0] {RUN_EXT, RUN_PANEL, RUN_NET, RUN_HELD} run_src_t;
  typedef enum logic [2:0] {FREQ_EXT, FREQ_PANEL, FREQ_COMB1, FREQ_NET, FREQ_HELD} freq_src_t;
endpackage

/* File: run_cmd_if.sv */
`timescale 1ns/10ps
`default_nettype none
`include "opmode_params.svh"
interface run_cmd_if;
  import opmode_pkg::*;
  run_src_t              run_src;
  freq_src_t             freq_src;
  logic                  held_fwd;
  logic                  held_rev;
  logic [`FREQ_W-1:0]    held_freq;
  logic                  cmd_fwd;
  logic                  cmd_rev;
  logic [`FREQ_W-1:0]    cmd_freq;
  modport ctrl (output run_src, freq_src, held_fwd, held_rev, held_freq,
                input cmd_fwd, cmd_rev, cmd_freq);
  modport mux  (input run_src, freq_src, held_fwd, held_rev, held_freq,
                output cmd_fwd, cmd_rev, cmd_freq);
endinterface
`default_nettype wire

/* File: run_cmd_mux.sv */
`timescale 1ns/10ps
`default_nettype none
`include "opmode_params.svh"
module run_cmd_mux
  import opmode_pkg::*;
(
  run_cmd_if.mux                    sel,              // source selection
  input  wire logic                 ext_fwd_in,       // forward start terminal
  input  wire logic                 ext_rev_in,       // reverse start terminal
  input  wire logic                 panel_fwd_in,     // panel forward run
  input  wire logic                 panel_rev_in,     // panel reverse run
  input  wire logic                 net_fwd_in,       // network forward run
  input  wire logic                 net_rev_in,       // network reverse run
  input  wire logic                 jog_in,           // jog selected
  input  wire logic                 multi_sel_in,     // a multi-speed is selected
  input  wire logic                 cur_en_in,        // current input enable
  input  wire logic [`FREQ_W-1:0]   jog_freq_in,      // jog frequency
  input  wire logic [`FREQ_W-1:0]   multi_freq_in,    // selected multi-speed
  input  wire logic [`FREQ_W-1:0]   volt_freq_in,     // voltage analog input
  input  wire logic [`FREQ_W-1:0]   cur_freq_in,      // current analog input
  input  wire logic [`FREQ_W-1:0]   panel_freq_in,    // panel set frequency
  input  wire logic [`FREQ_W-1:0]   net_freq_in       // network set frequency
);
  // external frequency: jog, then multi-speed, then analog
  logic [`FREQ_W-1:0] ext_freq;
  always_comb
  begin
    if (jog_in)
      ext_freq = jog_freq_in;
    else if (multi_sel_in)
      ext_freq = multi_freq_in;
    else if (cur_en_in)
      ext_freq = cur_freq_in;
    else
      ext_freq = volt_freq_in;
  end

  // run command source
  always_comb
  begin
    unique case (sel.run_src)
      RUN_EXT:   {sel.cmd_fwd, sel.cmd_rev} = {ext_fwd_in, ext_rev_in};
      RUN_PANEL: {sel.cmd_fwd, sel.cmd_rev} = {panel_fwd_in, panel_rev_in};
      RUN_NET:   {sel.cmd_fwd, sel.cmd_rev} = {net_fwd_in, net_rev_in};
      RUN_HELD:  {sel.cmd_fwd, sel.cmd_rev} = {sel.held_fwd, sel.held_rev};
    endcase
  end

  // frequency source; combined mode 1 lets multi-speed beat the panel
  always_comb
  begin
    unique case (sel.freq_src)
      FREQ_EXT:   sel.cmd_freq = ext_freq;
      FREQ_PANEL: sel.cmd_freq = panel_freq_in;
      FREQ_COMB1: sel.cmd_freq = multi_sel_in ? multi_freq_in :
                                 (cur_en_in ? cur_freq_in : panel_freq_in);
      FREQ_NET:   sel.cmd_freq = net_freq_in;
      FREQ_HELD:  sel.cmd_freq = sel.held_freq;
      default:    sel.cmd_freq = ext_freq;
    endcase
  end
endmodule
`default_nettype wire
